// ### txws_regs.vh
`ifndef TXWS_REGS_VH
`define TXWS_REGS_VH

// Register addresses
`define TXWS_ADDR_CFG1        8'h2E
`define TXWS_ADDR_CFG2        8'h2F
`define TXWS_ADDR_OV1         8'h30
`define TXWS_ADDR_AUX         8'h31
`define TXWS_ADDR_MODE        8'h40
`define TXWS_ADDR_IRQ_STAT    8'h41
`define TXWS_ADDR_IRQ_MASK    8'h42

// Writable bits; all others read as zero
`define TXWS_CFG1_WMASK       8'h0B
`define TXWS_CFG2_WMASK       8'h3F
`define TXWS_OV1_WMASK        8'hFF
`define TXWS_MODE_WMASK       8'h01
`define TXWS_IRQ_WMASK        8'h0F

// Reset values
`define TXWS_CFG1_RST         8'h00
`define TXWS_CFG2_RST         8'h00
`define TXWS_OV1_RST          8'h00
`define TXWS_MODE_RST         8'h00
`define TXWS_IRQ_RST          8'h00
`define TXWS_BYTE_ZERO        8'h00

// Shaping configuration one
`define TXWS_CFG1_CONT_BIT    3
`define TXWS_CFG1_RXONLY_BIT  1
`define TXWS_CFG1_ONOFF_BIT   0

// Shaping configuration two
`define TXWS_CFG2_SYM_BIT     5
`define TXWS_CFG2_SINK_BIT    4
`define TXWS_CFG2_FILT_MSB    3
`define TXWS_CFG2_FILT_LSB    0

// Overshoot configuration one
`define TXWS_OV1_LEVEL_MSB    7
`define TXWS_OV1_LEVEL_LSB    6
`define TXWS_OV1_CELL_MSB     5
`define TXWS_OV1_CELL_LSB     0

// Mode register
`define TXWS_MODE_RGS_BIT     0

// Status display bits
`define TXWS_AUX_CHAN_BIT     7
`define TXWS_AUX_EFD_BIT      6
`define TXWS_AUX_TX_BIT       5
`define TXWS_AUX_OSC_BIT      4
`define TXWS_AUX_RXON_BIT     3
`define TXWS_AUX_RXACT_BIT    2
`define TXWS_AUX_PEER_BIT     1
`define TXWS_AUX_CA_BIT       0

// Interrupt status bits
`define TXWS_IRQ_EFD_BIT      0
`define TXWS_IRQ_OSC_BIT      1
`define TXWS_IRQ_RXMSG_BIT    2
`define TXWS_IRQ_TXDONE_BIT   3

// Drive level codes
`define TXWS_DRV_MAIN         2'h0
`define TXWS_DRV_MOD          2'h1
`define TXWS_DRV_STOP         2'h2
`define TXWS_DRV_RSVD         2'h3

// Overshoot cell sequencing
`define TXWS_OV_CELLS         6
`define TXWS_CELL_DIV         4

`endif

// ### txws_cell_seq.v
`timescale 1ns/1ps
`default_nettype none

module txws_cell_seq #(
    parameter CELLS = 6,
    parameter IDX_W = 3,
    parameter DIV   = 4,
    parameter DIV_W = 8
) (
    // Clock and reset
    input  wire             clk_i,
    input  wire             rst_i,
    // Modulation period
    input  wire             start_i,
    input  wire             hold_i,
    // Current cell
    output reg  [IDX_W-1:0] cell_o,
    output reg              valid_o
);

    localparam [1:0] ST_IDLE = 2'h1;
    localparam [1:0] ST_RUN  = 2'h2;
    // Integer forms cut to width on purpose
    localparam integer     LAST_I    = CELLS - 1;
    localparam integer     DLAST_I   = DIV - 1;
    localparam [IDX_W-1:0] LAST_CELL = LAST_I[IDX_W-1:0];
    localparam [IDX_W-1:0] ZERO_CELL = {IDX_W{1'b0}};
    localparam [DIV_W-1:0] DIV_LAST  = DLAST_I[DIV_W-1:0];
    localparam [DIV_W-1:0] DIV_ZERO  = {DIV_W{1'b0}};

    reg [1:0]       state;
    reg [DIV_W-1:0] div_cnt;
    wire            step_en;

    // One cell per divider period
    assign step_en = (div_cnt == DIV_LAST);

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state   <= ST_IDLE;
            div_cnt <= DIV_ZERO;
            cell_o  <= ZERO_CELL;
            valid_o <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    div_cnt <= DIV_ZERO;
                    if (start_i) begin
                        state   <= ST_RUN;
                        cell_o  <= LAST_CELL;
                        valid_o <= 1'b1;
                    end
                end
                ST_RUN: begin
                    // Pattern stops as soon as the modulation period ends
                    if (!hold_i) begin
                        state   <= ST_IDLE;
                        valid_o <= 1'b0;
                    end else if (step_en) begin
                        div_cnt <= DIV_ZERO;
                        if (cell_o == ZERO_CELL) begin
                            state   <= ST_IDLE;
                            valid_o <= 1'b0;
                        end else begin
                            cell_o <= cell_o - 1'b1;
                        end
                    end else begin
                        div_cnt <= div_cnt + 1'b1;
                    end
                end
                default: begin
                    state   <= ST_IDLE;
                    valid_o <= 1'b0;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// ### txws_top.v
// What this block does
// - Rx-only clear: RF supply after each pause
// - Rx-only set: RF supply only during receive
// - On/off shaping bit shapes field transitions
// - Shaping configs act only in regulated mode
// - Symmetry bit: zero asymmetric, one symmetric
// - Sink bit: zero weak, one strong sink
// - Four-bit filter constant for AM reference
// - Status top bit: zero means AM channel
// - Status bit mirrors external field detector
// - Transmit active bit hides collision-avoid transmissions
// - Status bit shows oscillator stable
// - Status bits: decoder enabled, decoder receiving
// - Status bits: peer detect, collision avoid modes
// - Overshoot level: main, modulation, stop, reserved
// - Overshoot level ignored in regulated mode
// - Pattern cells pulse drive during modulation
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none

`include "txws_regs.vh"

module txws_top #(
    parameter CELL_DIV = `TXWS_CELL_DIV
) (
    // Clock and reset
    input  wire       clk_i,
    input  wire       rst_i,
    // Register port
    input  wire [7:0] addr_i,
    input  wire [7:0] wdata_i,
    input  wire       wr_i,
    input  wire       rd_i,
    output reg  [7:0] rdata_o,
    output reg        irq_o,
    // Front end status
    input  wire       rx_pm_channel_i,
    input  wire       ext_field_i,
    input  wire       tx_active_i,
    input  wire       tx_auto_ca_i,
    input  wire       osc_stable_i,
    input  wire       rx_enabled_i,
    input  wire       rx_receiving_i,
    input  wire       efd_peer_mode_i,
    input  wire       collision_avoid_detect_active_i,
    // Modulation timing
    input  wire       mod_pause_i,
    input  wire       rx_period_i,
    // Driver controls
    output reg        regulated_shaping_mode_o,
    output reg        rf_reg_continuous_o,
    output reg        rf_regulated_supply_sel_o,
    output reg        txonoff_shaping_o,
    output reg        shape_symmetry_select_o,
    output reg        mod_sink_strong_o,
    output reg  [3:0] am_reference_filter_constant_o,
    output reg  [1:0] overshoot_drive_level_o,
    output reg        overshoot_pulse_active_o
);

    // Software registers
    reg  [7:0] wave_shaping_config_one;
    reg  [7:0] wave_shaping_config_two;
    reg  [7:0] overshoot_protection_config_one;
    reg  [7:0] shaping_mode_ctrl;
    reg  [7:0] irq_status;
    reg  [7:0] irq_mask;

    // Live status
    reg  [7:0] auxiliary_status_display;
    reg  [7:0] aux_prev;
    reg        mod_pause_d;

    // Decoded strobes
    wire       wr_cfg1;
    wire       wr_cfg2;
    wire       wr_ov1;
    wire       wr_mode;
    wire       wr_stat;
    wire       wr_mask;

    // Derived controls
    wire       regulated_shaping_mode;
    wire [7:0] eff_cfg1;
    wire [7:0] eff_cfg2;
    wire [1:0] overshoot_drive_level;
    wire [5:0] overshoot_pulse_cells;
    wire [2:0] cell_idx;
    wire       cell_valid;
    wire       cell_bit;
    wire       pause_start;

    reg  [7:0] next_aux;
    reg  [7:0] next_irq_status;
    reg  [7:0] next_rdata;
    reg  [3:0] events;
    reg        next_rf_sel;
    reg  [1:0] next_drive;

    assign wr_cfg1 = wr_i && (addr_i == `TXWS_ADDR_CFG1);
    assign wr_cfg2 = wr_i && (addr_i == `TXWS_ADDR_CFG2);
    assign wr_ov1  = wr_i && (addr_i == `TXWS_ADDR_OV1);
    assign wr_mode = wr_i && (addr_i == `TXWS_ADDR_MODE);
    assign wr_stat = wr_i && (addr_i == `TXWS_ADDR_IRQ_STAT);
    assign wr_mask = wr_i && (addr_i == `TXWS_ADDR_IRQ_MASK);

    assign regulated_shaping_mode = shaping_mode_ctrl[`TXWS_MODE_RGS_BIT];

    // Outside regulated mode both configs read back but steer nothing
    assign eff_cfg1 = regulated_shaping_mode ? wave_shaping_config_one
                                             : `TXWS_BYTE_ZERO;
    assign eff_cfg2 = regulated_shaping_mode ? wave_shaping_config_two
                                             : `TXWS_BYTE_ZERO;

    assign overshoot_drive_level =
        overshoot_protection_config_one[`TXWS_OV1_LEVEL_MSB:`TXWS_OV1_LEVEL_LSB];
    assign overshoot_pulse_cells =
        overshoot_protection_config_one[`TXWS_OV1_CELL_MSB:`TXWS_OV1_CELL_LSB];

    assign pause_start = mod_pause_i && !mod_pause_d;
    assign cell_bit    = overshoot_pulse_cells[cell_idx];

    // Register writes; reserved bits never store
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wave_shaping_config_one         <= `TXWS_CFG1_RST;
            wave_shaping_config_two         <= `TXWS_CFG2_RST;
            overshoot_protection_config_one <= `TXWS_OV1_RST;
            shaping_mode_ctrl               <= `TXWS_MODE_RST;
            irq_mask                        <= `TXWS_IRQ_RST;
        end else begin
            if (wr_cfg1) begin
                wave_shaping_config_one <= wdata_i & `TXWS_CFG1_WMASK;
            end
            if (wr_cfg2) begin
                wave_shaping_config_two <= wdata_i & `TXWS_CFG2_WMASK;
            end
            if (wr_ov1) begin
                overshoot_protection_config_one <= wdata_i & `TXWS_OV1_WMASK;
            end
            if (wr_mode) begin
                shaping_mode_ctrl <= wdata_i & `TXWS_MODE_WMASK;
            end
            if (wr_mask) begin
                irq_mask <= wdata_i & `TXWS_IRQ_WMASK;
            end
        end
    end

    // Status display snapshot; it has no write path at all
    always @* begin
        next_aux = `TXWS_BYTE_ZERO;
        next_aux[`TXWS_AUX_CHAN_BIT]  = rx_pm_channel_i;
        next_aux[`TXWS_AUX_EFD_BIT]   = ext_field_i;
        next_aux[`TXWS_AUX_TX_BIT]    = tx_active_i && !tx_auto_ca_i;
        next_aux[`TXWS_AUX_OSC_BIT]   = osc_stable_i;
        next_aux[`TXWS_AUX_RXON_BIT]  = rx_enabled_i;
        next_aux[`TXWS_AUX_RXACT_BIT] = rx_receiving_i;
        next_aux[`TXWS_AUX_PEER_BIT]  = efd_peer_mode_i;
        next_aux[`TXWS_AUX_CA_BIT]    = collision_avoid_detect_active_i;
    end

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            auxiliary_status_display <= `TXWS_BYTE_ZERO;
            aux_prev                 <= `TXWS_BYTE_ZERO;
            mod_pause_d              <= 1'b0;
        end else begin
            auxiliary_status_display <= next_aux;
            aux_prev                 <= auxiliary_status_display;
            mod_pause_d              <= mod_pause_i;
        end
    end

    // Events from the display; compared one sample apart
    always @* begin
        events = 4'h0;
        events[`TXWS_IRQ_EFD_BIT] =
            auxiliary_status_display[`TXWS_AUX_EFD_BIT] &&
            !aux_prev[`TXWS_AUX_EFD_BIT];
        events[`TXWS_IRQ_OSC_BIT] =
            auxiliary_status_display[`TXWS_AUX_OSC_BIT] &&
            !aux_prev[`TXWS_AUX_OSC_BIT];
        events[`TXWS_IRQ_RXMSG_BIT] =
            auxiliary_status_display[`TXWS_AUX_RXACT_BIT] &&
            !aux_prev[`TXWS_AUX_RXACT_BIT];
        events[`TXWS_IRQ_TXDONE_BIT] =
            !auxiliary_status_display[`TXWS_AUX_TX_BIT] &&
            aux_prev[`TXWS_AUX_TX_BIT];
    end

    // Write one to clear; a new event in the same cycle survives
    always @* begin
        next_irq_status = irq_status;
        if (wr_stat) begin
            next_irq_status = irq_status & ~(wdata_i & `TXWS_IRQ_WMASK);
        end
        next_irq_status = next_irq_status | {4'h0, events};
    end

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_status <= `TXWS_IRQ_RST;
            irq_o      <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            irq_o      <= |(next_irq_status & irq_mask);
        end
    end

    // Read mux; unmapped addresses answer zero
    always @* begin
        next_rdata = `TXWS_BYTE_ZERO;
        case (addr_i)
            `TXWS_ADDR_CFG1:     next_rdata = wave_shaping_config_one;
            `TXWS_ADDR_CFG2:     next_rdata = wave_shaping_config_two;
            `TXWS_ADDR_OV1:      next_rdata = overshoot_protection_config_one;
            `TXWS_ADDR_AUX:      next_rdata = auxiliary_status_display;
            `TXWS_ADDR_MODE:     next_rdata = shaping_mode_ctrl;
            `TXWS_ADDR_IRQ_STAT: next_rdata = irq_status;
            `TXWS_ADDR_IRQ_MASK: next_rdata = irq_mask;
            default:             next_rdata = `TXWS_BYTE_ZERO;
        endcase
    end

    // Data stand only in the cycle after the read strobe
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= `TXWS_BYTE_ZERO;
        end else if (rd_i) begin
            rdata_o <= next_rdata;
        end else begin
            rdata_o <= `TXWS_BYTE_ZERO;
        end
    end

    // Overshoot cells, stepped from the start of each modulation period
    txws_cell_seq #(
        .CELLS (`TXWS_OV_CELLS),
        .IDX_W (3),
        .DIV   (CELL_DIV),
        .DIV_W (8)
    ) u_cell_seq (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .start_i (pause_start),
        .hold_i  (mod_pause_i),
        .cell_o  (cell_idx),
        .valid_o (cell_valid)
    );

    // Supply choice for the transmit driver
    always @* begin
        if (eff_cfg1[`TXWS_CFG1_RXONLY_BIT]) begin
            next_rf_sel = rx_period_i;
        end else begin
            // Back on the RF regulator once each pause has ended
            next_rf_sel = !mod_pause_i;
        end
    end

    // Drive level per cell
    always @* begin
        next_drive = `TXWS_DRV_MAIN;
        if (cell_valid) begin
            if (regulated_shaping_mode) begin
                next_drive = cell_bit ? `TXWS_DRV_MOD : `TXWS_DRV_MAIN;
            end else if (cell_bit) begin
                // Reserved level is treated as normal drive
                case (overshoot_drive_level)
                    `TXWS_DRV_MAIN: next_drive = `TXWS_DRV_MAIN;
                    `TXWS_DRV_MOD:  next_drive = `TXWS_DRV_MOD;
                    `TXWS_DRV_STOP: next_drive = `TXWS_DRV_STOP;
                    default:        next_drive = `TXWS_DRV_MAIN;
                endcase
            end
        end
    end

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            regulated_shaping_mode_o       <= 1'b0;
            rf_reg_continuous_o            <= 1'b0;
            rf_regulated_supply_sel_o      <= 1'b0;
            txonoff_shaping_o              <= 1'b0;
            shape_symmetry_select_o        <= 1'b0;
            mod_sink_strong_o              <= 1'b0;
            am_reference_filter_constant_o <= 4'h0;
            overshoot_drive_level_o        <= `TXWS_DRV_MAIN;
            overshoot_pulse_active_o       <= 1'b0;
        end else begin
            regulated_shaping_mode_o       <= regulated_shaping_mode;
            rf_reg_continuous_o            <= eff_cfg1[`TXWS_CFG1_CONT_BIT];
            rf_regulated_supply_sel_o      <= next_rf_sel;
            txonoff_shaping_o              <= eff_cfg1[`TXWS_CFG1_ONOFF_BIT];
            shape_symmetry_select_o        <= eff_cfg2[`TXWS_CFG2_SYM_BIT];
            mod_sink_strong_o              <= eff_cfg2[`TXWS_CFG2_SINK_BIT];
            am_reference_filter_constant_o <=
                eff_cfg2[`TXWS_CFG2_FILT_MSB:`TXWS_CFG2_FILT_LSB];
            overshoot_drive_level_o        <= next_drive;
            overshoot_pulse_active_o       <= cell_valid;
        end
    end

endmodule

`default_nettype wire

// ### txws_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "txws_regs.vh"
module txws_monitor #(
    parameter CELL_DIV = 4
) (
    // Clock and reset
    input wire logic       clk_i,
    input wire logic       rst_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic       irq_o,
    // Modulation and driver controls
    input wire logic       mod_pause_i,
    input wire logic       regulated_shaping_mode_o,
    input wire logic       rf_reg_continuous_o,
    input wire logic       rf_regulated_supply_sel_o,
    input wire logic       txonoff_shaping_o,
    input wire logic       shape_symmetry_select_o,
    input wire logic       mod_sink_strong_o,
    input wire logic [3:0] am_reference_filter_constant_o,
    input wire logic [1:0] overshoot_drive_level_o,
    input wire logic       overshoot_pulse_active_o
);
    default clocking mcb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Length of one uninterrupted cell sequence
    int unsigned act_cnt;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) act_cnt <= 0;
        else act_cnt <= overshoot_pulse_active_o ? act_cnt + 1 : 0;
    end

    rdata_idle_a: assert property (
        !$past(rd_i) |-> rdata_o == 8'h00) else $error("read data outside read slot");
    cfg_gated_a: assert property (
        !regulated_shaping_mode_o && !$past(regulated_shaping_mode_o) |->
        {rf_reg_continuous_o, txonoff_shaping_o, shape_symmetry_select_o, mod_sink_strong_o,
         am_reference_filter_constant_o} == 8'h00) else $error("shaping config leaks");
    rf_sel_a: assert property (
        !$past(rst_i) && !regulated_shaping_mode_o && !$past(regulated_shaping_mode_o) |->
        rf_regulated_supply_sel_o == !$past(mod_pause_i)) else $error("supply select wrong");
    lvl_rsvd_a: assert property (
        overshoot_drive_level_o != `TXWS_DRV_RSVD) else $error("reserved drive level");
    no_stop_a: assert property (
        regulated_shaping_mode_o && $past(regulated_shaping_mode_o)
        && $past(regulated_shaping_mode_o, 2) |-> overshoot_drive_level_o != `TXWS_DRV_STOP)
        else $error("driver stop in regulated mode");
    pulse_in_pause_a: assert property (
        overshoot_pulse_active_o |-> $past(mod_pause_i) || $past(mod_pause_i, 2)
        || $past(mod_pause_i, 3)) else $error("pulse outside pause");
    pulse_start_a: assert property (
        $rose(mod_pause_i) ##1 mod_pause_i [*4] |-> overshoot_pulse_active_o)
        else $error("pulse sequence not started");
    seq_len_a: assert property (
        act_cnt <= `TXWS_OV_CELLS * CELL_DIV + 2) else $error("pulse sequence too long");
    irq_mask_a: assert property (
        wr_i && addr_i == `TXWS_ADDR_IRQ_MASK && wdata_i[3:0] == 4'h0
        ##1 !(wr_i && addr_i == `TXWS_ADDR_IRQ_MASK) |-> ##1 !irq_o)
        else $error("interrupt while masked");

    cover property ($rose(irq_o));
    cover property ($rose(overshoot_pulse_active_o));
    cover property (rd_i && addr_i == `TXWS_ADDR_AUX);
endmodule

bind txws_top txws_monitor #(.CELL_DIV(CELL_DIV)) mon_u (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .mod_pause_i(mod_pause_i),
    .regulated_shaping_mode_o(regulated_shaping_mode_o),
    .rf_reg_continuous_o(rf_reg_continuous_o),
    .rf_regulated_supply_sel_o(rf_regulated_supply_sel_o),
    .txonoff_shaping_o(txonoff_shaping_o), .shape_symmetry_select_o(shape_symmetry_select_o),
    .mod_sink_strong_o(mod_sink_strong_o),
    .am_reference_filter_constant_o(am_reference_filter_constant_o),
    .overshoot_drive_level_o(overshoot_drive_level_o),
    .overshoot_pulse_active_o(overshoot_pulse_active_o)
);
`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "txws_regs.vh"
module testbench;
    logic       clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic [7:0] addr_i, wdata_i, rdata_o;
    logic       wr_i, rd_i, irq_o, rx_pm_channel_i, ext_field_i, tx_active_i, tx_auto_ca_i;
    logic       osc_stable_i, rx_enabled_i, rx_receiving_i, efd_peer_mode_i;
    logic       collision_avoid_detect_active_i, mod_pause_i, rx_period_i;
    logic       regulated_shaping_mode_o, rf_reg_continuous_o, rf_regulated_supply_sel_o;
    logic       txonoff_shaping_o, shape_symmetry_select_o, mod_sink_strong_o;
    logic [3:0] am_reference_filter_constant_o;
    logic [1:0] overshoot_drive_level_o;
    logic       overshoot_pulse_active_o;
    int         fails = 0;
    int         n_compared = 0;
    logic [7:0] regs [7] = '{`TXWS_ADDR_CFG1, `TXWS_ADDR_CFG2, `TXWS_ADDR_OV1, `TXWS_ADDR_AUX,
                             8'h50, `TXWS_ADDR_MODE, `TXWS_ADDR_IRQ_MASK};

    always #2 clk_i = ~clk_i;

    // Short cells keep the overshoot runs brief
    txws_top #(.CELL_DIV(2)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .rx_pm_channel_i(rx_pm_channel_i),
        .ext_field_i(ext_field_i), .tx_active_i(tx_active_i), .tx_auto_ca_i(tx_auto_ca_i),
        .osc_stable_i(osc_stable_i), .rx_enabled_i(rx_enabled_i),
        .rx_receiving_i(rx_receiving_i), .efd_peer_mode_i(efd_peer_mode_i),
        .collision_avoid_detect_active_i(collision_avoid_detect_active_i),
        .mod_pause_i(mod_pause_i), .rx_period_i(rx_period_i),
        .regulated_shaping_mode_o(regulated_shaping_mode_o),
        .rf_reg_continuous_o(rf_reg_continuous_o),
        .rf_regulated_supply_sel_o(rf_regulated_supply_sel_o),
        .txonoff_shaping_o(txonoff_shaping_o), .shape_symmetry_select_o(shape_symmetry_select_o),
        .mod_sink_strong_o(mod_sink_strong_o),
        .am_reference_filter_constant_o(am_reference_filter_constant_o),
        .overshoot_drive_level_o(overshoot_drive_level_o),
        .overshoot_pulse_active_o(overshoot_pulse_active_o));

    task automatic print_verdict;
        if (fails == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask

    task automatic set_st(input logic [7:0] v, input logic ca);
        @(posedge clk_i);
        rx_pm_channel_i <= v[7];
        ext_field_i <= v[6];
        tx_active_i <= v[5];
        osc_stable_i <= v[4];
        rx_enabled_i <= v[3];
        rx_receiving_i <= v[2];
        efd_peer_mode_i <= v[1];
        collision_avoid_detect_active_i <= v[0];
        tx_auto_ca_i <= ca;
        tick(2);
    endtask

    task automatic chk_cfg(input logic [7:0] exp);
        tick(2);
        chk({rf_reg_continuous_o, txonoff_shaping_o, shape_symmetry_select_o,
             mod_sink_strong_o, am_reference_filter_constant_o}, exp);
    endtask

    task automatic t_regs;
        logic [7:0] e [7] = '{8'h0B, 8'h3F, 8'hFF, 8'h00, 8'h00, 8'h01, 8'h0F};
        foreach (regs[i]) rdchk(regs[i], 8'h00);
        foreach (regs[i]) wr(regs[i], 8'hFF);
        foreach (regs[i]) rdchk(regs[i], e[i]);
        wr(`TXWS_ADDR_IRQ_MASK, 8'h00);
    endtask

    task automatic t_gate;
        chk_cfg(8'hFF);
        wr(`TXWS_ADDR_CFG2, 8'h25);
        wr(`TXWS_ADDR_CFG1, 8'h08);
        chk_cfg(8'hA5);
        wr(`TXWS_ADDR_MODE, 8'h00);
        chk_cfg(8'h00);
        chk({7'h00, regulated_shaping_mode_o}, 8'h00);
        wr(`TXWS_ADDR_MODE, 8'h01);
        chk_cfg(8'hA5);
        chk({7'h00, regulated_shaping_mode_o}, 8'h01);
    endtask

    task automatic t_supply;
        for (int i = 0; i < 8; i++) begin
            if (i == 4) wr(`TXWS_ADDR_CFG1, 8'h0A);
            @(posedge clk_i);
            mod_pause_i <= i[0];
            rx_period_i <= i[1];
            tick(2);
            chk({7'h00, rf_regulated_supply_sel_o}, {7'h00, (i < 4) ? !i[0] : i[1]});
        end
        @(posedge clk_i);
        mod_pause_i <= 1'b0;
        rx_period_i <= 1'b0;
    endtask

    task automatic t_status;
        for (int i = 0; i < 8; i++) begin
            set_st(8'h01 << i, 1'b0);
            rdchk(`TXWS_ADDR_AUX, 8'h01 << i);
        end
        set_st(8'h20, 1'b1);
        rdchk(`TXWS_ADDR_AUX, 8'h00);
        set_st(8'h24, 1'b0);
        wr(`TXWS_ADDR_AUX, 8'h00);
        rdchk(`TXWS_ADDR_AUX, 8'h24);
        set_st(8'h00, 1'b0);
    endtask

    task automatic t_irq;
        int n;
        // Field, oscillator and receive rises plus a transmit fall were all seen
        rdchk(`TXWS_ADDR_IRQ_STAT, 8'h0F);
        wr(`TXWS_ADDR_IRQ_STAT, 8'h0F);
        rdchk(`TXWS_ADDR_IRQ_STAT, 8'h00);
        wr(`TXWS_ADDR_IRQ_MASK, 8'h01);
        set_st(8'h40, 1'b0);
        n = 0;
        while (irq_o !== 1'b1 && n < 10) begin
            tick(1);
            n++;
        end
        chk({7'h00, irq_o}, 8'h01);
        if (n == 10) print_verdict();
        rdchk(`TXWS_ADDR_IRQ_STAT, 8'h01);
        wr(`TXWS_ADDR_IRQ_MASK, 8'h00);
        tick(2);
        chk({7'h00, irq_o}, 8'h00);
        wr(`TXWS_ADDR_IRQ_MASK, 8'h01);
        tick(2);
        chk({7'h00, irq_o}, 8'h01);
        wr(`TXWS_ADDR_IRQ_STAT, 8'h01);
        tick(2);
        chk({7'h00, irq_o}, 8'h00);
        rdchk(`TXWS_ADDR_IRQ_STAT, 8'h00);
        set_st(8'h00, 1'b0);
    endtask

    // Collects every drive level seen around one modulation pause
    task automatic ov_run(input logic [7:0] ov, input logic m, input logic [7:0] exp);
        logic [3:0] seen;
        logic       act;
        seen = 4'h0;
        act = 1'b0;
        wr(`TXWS_ADDR_OV1, ov);
        wr(`TXWS_ADDR_MODE, {7'h00, m});
        tick(2);
        @(posedge clk_i);
        mod_pause_i <= 1'b1;
        for (int i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (i == 15) mod_pause_i <= 1'b0;
            #1;
            seen[overshoot_drive_level_o] = 1'b1;
            act = act | overshoot_pulse_active_o;
        end
        chk({act, 3'h0, seen}, exp);
    endtask

    task automatic t_over;
        ov_run(8'hAA, 1'b0, 8'h85);
        ov_run(8'hAA, 1'b1, 8'h83);
        ov_run(8'h7F, 1'b0, 8'h83);
        ov_run(8'hFF, 1'b0, 8'h81);
    endtask

    initial begin
        {wr_i, rd_i, addr_i, wdata_i, rx_pm_channel_i, ext_field_i, tx_active_i, tx_auto_ca_i,
         osc_stable_i, rx_enabled_i, rx_receiving_i, efd_peer_mode_i, mod_pause_i,
         collision_avoid_detect_active_i, rx_period_i} = '0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_gate();
        t_supply();
        t_status();
        t_irq();
        t_over();
        print_verdict();
    end
endmodule
`default_nettype wire
